// *** hw/cprc_pkg.sv ***
// constants shared by the crosspoint route control block
// assumes one 100 MHz clock and byte addresses on the register bus
package cprc_pkg;
  localparam int          CLK_MHZ     = 100;
  localparam int          CLK_KHZ     = 1000 * CLK_MHZ;
  // power-up time of the outputs, longest, in microseconds
  localparam int          T_ON_US     = 20;
  localparam int          T_ON_CYC    = T_ON_US * CLK_MHZ;
  localparam int          PWR_CNT_W   = 12;
  // clock-low timeout of the management bus, least, in milliseconds
  localparam int          T_TMO_MS    = 25;
  localparam int          TMO_CYC     = T_TMO_MS * CLK_KHZ;
  localparam int          TMO_CNT_W   = 22;
  // register offsets (byte addresses) and indices
  localparam logic [31:0] OFF_CTRL    = 32'h0000_0000;
  localparam logic [31:0] OFF_ROUTE   = 32'h0000_0004;
  localparam logic [31:0] OFF_TXLVL   = 32'h0000_0008;
  localparam logic [31:0] OFF_RXLVL   = 32'h0000_000C;
  localparam logic [31:0] OFF_LOS     = 32'h0000_0010;
  localparam logic [31:0] OFF_STAT    = 32'h0000_0014;
  localparam logic [2:0]  IDX_CTRL    = 3'h0;
  localparam logic [2:0]  IDX_ROUTE   = 3'h1;
  localparam logic [2:0]  IDX_TXLVL   = 3'h2;
  localparam logic [2:0]  IDX_RXLVL   = 3'h3;
  localparam logic [2:0]  IDX_LOS     = 3'h4;
  localparam logic [2:0]  IDX_STAT    = 3'h5;
  // field positions and reset values
  localparam int          CTRL_SOFTPWR = 7;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  ROUTE_RST   = 8'hE4;
  localparam logic [7:0]  LVL_RST     = 8'h00;
  localparam int          STAT_SMB    = 0;
  localparam int          STAT_PWR    = 1;
  localparam int          STAT_ACT    = 2;
  localparam int          STAT_TMO    = 3;
  // signal conditioning levels
  localparam logic [1:0]  LVL_OFF     = 2'h0;
  localparam logic [1:0]  LVL_LOW     = 2'h1;
  localparam logic [1:0]  LVL_MED     = 2'h2;
  localparam logic [1:0]  LVL_HIGH    = 2'h3;
  // slave address: upper three bits fixed, value arbitrary
  localparam logic [2:0]  SMB_ADDR_HI = 3'h5;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
endpackage : cprc_pkg

// *** hw/cprc_smb_slave.sv ***
// byte-wide management bus slave: pointer write, data write, data read
// assumes bus pins sampled synchronously to hclk, open-drain data
`timescale 1ns/1ns
module cprc_smb_slave
  import cprc_pkg::*;
#(
  parameter int TMO = TMO_CYC
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       en,
  // bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe,
  input  wire logic [6:0] addr,
  // register side
  output logic            wr_q,
  output logic [7:0]      ptr_q,
  output logic [7:0]      wdata_q,
  input  wire logic [7:0] rdata,
  output logic            tmo_q
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_ADDR = 9'h002, S_ACKA = 9'h004,
    S_CMD  = 9'h008, S_ACKC = 9'h010, S_WDAT = 9'h020,
    S_ACKW = 9'h040, S_RDAT = 9'h080, S_ACKR = 9'h100
  } cprc_smb_st_t;

  cprc_smb_st_t            st_q;
  logic                    scl_q;
  logic                    sda_q;
  logic                    rw_q;
  logic [7:0]              sh_q;
  logic [3:0]              cnt_q;
  logic [TMO_CNT_W-1:0]    low_q;
  logic                    rise;
  logic                    fall;
  logic                    start;
  logic                    stop;
  logic                    tmo;

  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;
  assign tmo   = (low_q == TMO_CNT_W'(TMO));

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // clock-low timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q <= '0;
      tmo_q <= 1'b0;
    end else if (ce) begin
      low_q <= (!en || scl_i || tmo) ? '0 : low_q + 1'b1; // RQ19
      tmo_q <= tmo;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= S_IDLE;
      sh_q    <= '0;
      cnt_q   <= '0;
      rw_q    <= 1'b0;
      ptr_q   <= '0;
      wdata_q <= '0;
      wr_q    <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (ce) begin
      wr_q <= 1'b0;
      if (!en || stop || tmo) begin // RQ19
        st_q   <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (start) begin
        st_q   <= S_ADDR;
        cnt_q  <= '0;
        sda_oe <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR, S_CMD, S_WDAT: begin
            if (rise) begin
              sh_q  <= {sh_q[6:0], sda_i};
              cnt_q <= cnt_q + 1'b1;
            end else if (fall && cnt_q == 4'h8) begin
              cnt_q  <= '0;
              sda_oe <= 1'b1;
              if (st_q == S_ADDR) begin
                if (sh_q[7:1] == addr) begin // RQ8
                  rw_q <= sh_q[0];
                  st_q <= S_ACKA;
                end else begin
                  sda_oe <= 1'b0;
                  st_q   <= S_IDLE;
                end
              end else if (st_q == S_CMD) begin
                ptr_q <= sh_q;
                st_q  <= S_ACKC;
              end else begin
                wdata_q <= sh_q;
                wr_q    <= 1'b1;
                st_q    <= S_ACKW;
              end
            end
          end
          S_ACKA, S_ACKC, S_ACKW: begin
            if (fall) begin
              if (st_q == S_ACKA && rw_q) begin
                sh_q   <= rdata;
                sda_oe <= ~rdata[7];
                st_q   <= S_RDAT;
              end else begin
                sda_oe <= 1'b0;
                st_q   <= (st_q == S_ACKA) ? S_CMD : S_WDAT;
                if (st_q == S_ACKW) ptr_q <= ptr_q + 1'b1;
              end
            end
          end
          S_RDAT: begin
            if (rise) begin
              cnt_q <= cnt_q + 1'b1;
            end else if (fall) begin
              if (cnt_q == 4'h8) begin
                cnt_q  <= '0;
                sda_oe <= 1'b0;
                st_q   <= S_ACKR;
              end else begin
                sh_q   <= {sh_q[6:0], 1'b0};
                sda_oe <= ~sh_q[6];
              end
            end
          end
          S_ACKR: begin
            if (rise) begin
              if (sda_i) st_q <= S_IDLE;
              else ptr_q <= ptr_q + 1'b1;
            end else if (fall) begin
              sh_q   <= rdata;
              sda_oe <= ~rdata[7];
              st_q   <= S_RDAT;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  AST_SMB_IDLE_OFF: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    (ce && !en) |=> (st_q == S_IDLE && !sda_oe))
    else $error("bus slave active outside management mode");
endmodule : cprc_smb_slave

// *** hw/cprc_top.sv ***
// crosspoint route control: routing, power, conditioning, loss monitors
// assumes pins synchronous to hclk; registers reached over AHB-Lite
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// RQ1: any input may drive any output, several outputs at once, no blocking
// RQ2: mode pin high selects management bus mode, low selects pin mode
// RQ3: every toggle of the mode pin resets all management registers
// RQ4: mode pin pulled low in the pad, floating means pin mode
// RQ5: in pin mode each output has its own select pin pair
// RQ6: select pair as binary, bit1 most significant, picks input of that index
// RQ7: in bus mode output-zero pair becomes bus clock and data line
// RQ8: in bus mode output-one and output-two pairs are four address straps
// RQ9: in bus mode output-three pair is ignored, board ties it
// RQ10: in pin mode low power-down pin powers the device down
// RQ11: bus interface stays reachable while powered down in bus mode
// RQ12: in bus mode power up when pin high or soft power bit set
// RQ13: in bus mode power down only when pin low and soft bit clear
// RQ14: equalization select pins act in both modes
// RQ15: pre-emphasis select pins act in both modes
// RQ16: registers set each channel level to off, low, medium or high
// RQ17: pins give pre-emphasis off or medium, equalization off or low
// RQ18: in bus mode loss-of-signal monitors report open inputs
// RQ19: bus clock held low past 25 ms is a bus timeout
// RQ20: outputs active within 20 us after power-down pin rises
module cprc_top
  import cprc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int TMO = TMO_CYC
) (
  // clock, reset, enable
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // mode and power pins
  input  wire logic             smb_enable_pin,
  input  wire logic             power_down_pin,
  // route select pins and bus data drive
  input  wire logic             route_sel_switch_output0_bit0,
  input  wire logic             route_sel_switch_output0_bit1,
  input  wire logic             route_sel_out1_bit0,
  input  wire logic             route_sel_out1_bit1,
  input  wire logic             route_sel_out2_bit0,
  input  wire logic             route_sel_out2_bit1,
  input  wire logic             route_sel_out3_bit0,
  input  wire logic             route_sel_out3_bit1,
  output logic                  smb_data_o,
  output logic                  smb_data_oe,
  // conditioning select pins
  input  wire logic             tx_boost_sel0,
  input  wire logic             tx_boost_sel1,
  input  wire logic             tx_boost_sel2,
  input  wire logic             tx_boost_sel3,
  input  wire logic             rx_comp_sel0,
  input  wire logic             rx_comp_sel1,
  input  wire logic             rx_comp_sel2,
  input  wire logic             rx_comp_sel3,
  // datapath
  input  wire logic [NCH-1:0]   switch_in,
  input  wire logic [NCH-1:0]   sig_present,
  output logic [NCH-1:0]        switch_output_n,
  output logic [2*NCH-1:0]      tx_boost_level,
  output logic [2*NCH-1:0]      rx_comp_level,
  output logic                  outputs_active
);
  logic [2*NCH-1:0] pin_sel;
  logic [NCH-1:0]   pe_pin;
  logic [NCH-1:0]   eq_pin;
  logic             smb_mode;
  logic             mode_q;
  logic             mode_tgl;
  logic [7:0]       ctrl_q;
  logic [7:0]       route_q;
  logic [7:0]       txlvl_q;
  logic [7:0]       rxlvl_q;
  logic [NCH-1:0]   los_q;
  logic             tmo_st_q;
  logic [2*NCH-1:0] sel_q;
  logic             pwr_q;
  logic             pwr_d;
  logic [PWR_CNT_W-1:0] ton_q;
  logic             ap_wr_q;
  logic [2:0]       ap_idx_q;
  logic             ap_ok_q;
  logic             ap_take;
  logic             ap_ok;
  logic             smb_wr;
  logic [7:0]       smb_ptr;
  logic [7:0]       smb_wdata;
  logic             smb_tmo;
  logic             we;
  logic [2:0]       widx;
  logic [7:0]       wdat;
  logic [7:0]       smb_rdata;

  assign pin_sel = {route_sel_out3_bit1, route_sel_out3_bit0, route_sel_out2_bit1,
                    route_sel_out2_bit0, route_sel_out1_bit1, route_sel_out1_bit0,
                    route_sel_switch_output0_bit1, route_sel_switch_output0_bit0};
  assign pe_pin  = {tx_boost_sel3, tx_boost_sel2, tx_boost_sel1, tx_boost_sel0};
  assign eq_pin  = {rx_comp_sel3, rx_comp_sel2, rx_comp_sel1, rx_comp_sel0};
  // pad pulldown makes an open pin read low, pin mode
  assign smb_mode = smb_enable_pin; // RQ2 RQ4
  assign mode_tgl = smb_mode ^ mode_q;

  function automatic logic [7:0] rd_reg(input logic [2:0] idx);
    case (idx)
      IDX_CTRL:  rd_reg = ctrl_q;
      IDX_ROUTE: rd_reg = route_q;
      IDX_TXLVL: rd_reg = txlvl_q;
      IDX_RXLVL: rd_reg = rxlvl_q;
      IDX_LOS:   rd_reg = {sig_present, los_q};
      IDX_STAT: begin
        rd_reg = '0;
        rd_reg[STAT_SMB] = smb_mode;
        rd_reg[STAT_PWR] = pwr_q;
        rd_reg[STAT_ACT] = outputs_active;
        rd_reg[STAT_TMO] = tmo_st_q;
      end
      default:   rd_reg = '0;
    endcase
  endfunction : rd_reg

  ////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = ce && hsel && hready && (htrans == HTRANS_NSEQ);
  assign ap_ok     = (haddr[31:5] == '0) && (haddr[4:2] <= IDX_STAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q  <= 1'b0;
      ap_idx_q <= '0;
      ap_ok_q  <= 1'b0;
      hrdata   <= '0;
    end else if (ce) begin
      ap_wr_q  <= ap_take && hwrite;
      ap_idx_q <= haddr[4:2];
      ap_ok_q  <= ap_ok;
      if (ap_take && !hwrite) hrdata <= ap_ok ? {24'h0, rd_reg(haddr[4:2])} : '0;
    end
  end

  // bus write port; ahb wins a same-cycle clash
  always_comb begin
    we   = 1'b0;
    widx = smb_ptr[2:0];
    wdat = smb_wdata;
    if (ap_wr_q && ap_ok_q) begin
      we   = 1'b1;
      widx = ap_idx_q;
      wdat = hwdata[7:0];
    end else if (smb_wr && smb_ptr[7:3] == '0) begin
      we = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // slave read mux, process follows every register the function reads
  always_comb smb_rdata = rd_reg(smb_ptr[2:0]);

  // management bus slave on route pins of output zero
  cprc_smb_slave #(.TMO(TMO)) u_smb (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .en      (smb_mode), // RQ11
    .scl_i   (route_sel_switch_output0_bit0), // RQ7
    .sda_i   (route_sel_switch_output0_bit1), // RQ7
    .sda_oe  (smb_data_oe),
    .addr    ({SMB_ADDR_HI, pin_sel[5:2]}), // RQ8
    .wr_q    (smb_wr),
    .ptr_q   (smb_ptr),
    .wdata_q (smb_wdata),
    .rdata   (smb_rdata),
    .tmo_q   (smb_tmo)
  );
  assign smb_data_o = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // registers, cleared on every mode toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q   <= 1'b0;
      ctrl_q   <= CTRL_RST;
      route_q  <= ROUTE_RST;
      txlvl_q  <= LVL_RST;
      rxlvl_q  <= LVL_RST;
    end else if (ce) begin
      mode_q <= smb_mode;
      if (mode_tgl) begin // RQ3
        ctrl_q  <= CTRL_RST;
        route_q <= ROUTE_RST;
        txlvl_q <= LVL_RST;
        rxlvl_q <= LVL_RST;
      end else if (we) begin
        if (widx == IDX_CTRL)  ctrl_q  <= wdat;
        if (widx == IDX_ROUTE) route_q <= wdat;
        if (widx == IDX_TXLVL) txlvl_q <= wdat; // RQ16
        if (widx == IDX_RXLVL) rxlvl_q <= wdat; // RQ16
      end
    end
  end

  // sticky loss and timeout flags, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      los_q    <= '0;
      tmo_st_q <= 1'b0;
    end else if (ce) begin
      if (mode_tgl) begin // RQ3
        los_q    <= '0;
        tmo_st_q <= 1'b0;
      end else begin
        los_q <= (los_q & ~((we && widx == IDX_LOS) ? wdat[NCH-1:0] : '0))
                 | (smb_mode ? ~sig_present : '0); // RQ18
        tmo_st_q <= smb_tmo | (tmo_st_q & ~(we && widx == IDX_STAT && wdat[STAT_TMO]));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power state and power-up delay
  always_comb begin
    if (smb_mode) pwr_d = power_down_pin | ctrl_q[CTRL_SOFTPWR]; // RQ12 RQ13
    else pwr_d = power_down_pin; // RQ10
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_q          <= 1'b0;
      ton_q          <= '0;
      outputs_active <= 1'b0;
    end else if (ce) begin
      pwr_q <= pwr_d;
      if (!pwr_q) begin
        ton_q          <= '0;
        outputs_active <= 1'b0;
      end else if (ton_q != PWR_CNT_W'(T_ON_CYC)) begin
        ton_q <= ton_q + 1'b1;
      end else begin
        outputs_active <= 1'b1; // RQ20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-output route, switch and conditioning
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sel_q[2*i+:2]          <= '0;
        switch_output_n[i]     <= 1'b0;
        tx_boost_level[2*i+:2] <= LVL_OFF;
        rx_comp_level[2*i+:2]  <= LVL_OFF;
      end else if (ce) begin
        sel_q[2*i+:2] <= smb_mode ? route_q[2*i+:2] : pin_sel[2*i+:2]; // RQ5 RQ6 RQ9
        switch_output_n[i] <= outputs_active & switch_in[sel_q[2*i+:2]]; // RQ1
        if (pe_pin[i]) tx_boost_level[2*i+:2] <= LVL_MED; // RQ15 RQ17
        else tx_boost_level[2*i+:2] <= smb_mode ? txlvl_q[2*i+:2] : LVL_OFF;
        if (eq_pin[i]) rx_comp_level[2*i+:2] <= LVL_LOW; // RQ14 RQ17
        else rx_comp_level[2*i+:2] <= smb_mode ? rxlvl_q[2*i+:2] : LVL_OFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wake;
    ce && !pwr_q ##1 pwr_q;
  endsequence

  AST_PIN_ROUTE: assert property ( // RQ6
    (ce && !smb_mode) |=> sel_q[1:0] == $past({route_sel_switch_output0_bit1, route_sel_switch_output0_bit0}))
    else $error("pin route of output zero wrong");
  AST_OUT3_IGNORED: assert property ( // RQ9
    (ce && smb_mode && $stable(route_q)) |=> sel_q[7:6] == $past(route_q[7:6]))
    else $error("output three route follows pins in bus mode");
  AST_MODE_RESET: assert property ( // RQ3
    (ce && mode_tgl) |=> (ctrl_q == CTRL_RST && route_q == ROUTE_RST && los_q == '0))
    else $error("registers not reset on mode toggle");
  AST_PIN_POWER_DOWN_PIN: assert property ( // RQ10
    (ce && !smb_mode && !power_down_pin) |=> !pwr_q ##1 !outputs_active)
    else $error("pin mode power down not taken");
  AST_SOFT_UP: assert property ( // RQ12
    (ce && smb_mode && !mode_tgl && ctrl_q[CTRL_SOFTPWR]) |=> pwr_q)
    else $error("soft power bit did not power up");
  AST_BOTH_DOWN: assert property ( // RQ13
    (ce && smb_mode && !power_down_pin && !ctrl_q[CTRL_SOFTPWR]) |=> !pwr_q)
    else $error("powered with pin low and soft bit clear");
  AST_WAKE_HOLD: assert property ( // RQ20
    s_wake |-> !outputs_active [*8])
    else $error("outputs active before power-up delay");
  AST_WAKE_DONE: assert property ( // RQ20
    (ce && pwr_q && ton_q == PWR_CNT_W'(T_ON_CYC)) |=> outputs_active)
    else $error("outputs not active after power-up delay");
  AST_LOS_SET: assert property ( // RQ18
    (ce && smb_mode && !mode_tgl && !sig_present[0]) |=> los_q[0])
    else $error("loss of signal not flagged");
  AST_PE_PIN: assert property ( // RQ15
    (ce && tx_boost_sel0) |=> tx_boost_level[1:0] == LVL_MED)
    else $error("pre-emphasis pin not medium");
endmodule : cprc_top

// *** verification/cprc_smb_host.sv ***
// management bus host model: bit-banged write and read transfers, clock held low
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ns
module cprc_smb_host (
  // clock
  input  wire logic hclk,
  // bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic tick();
    repeat (4) @(posedge hclk);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick();
    scl <= 1'h1;
    tick();
    r = sda;
    scl <= 1'h0;
    tick();
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask : byte_io
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic [2:0] ack);
    sda_low <= 1'h1;
    tick();
    scl <= 1'h0;
    tick();
    byte_io({a, 1'h0}, ack[2]);
    byte_io(p, ack[1]);
    byte_io(d, ack[0]);
    sda_low <= 1'h1;
    tick();
    scl <= 1'h1;
    tick();
    sda_low <= 1'h0;
    tick();
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ack);
    logic r;
    sda_low <= 1'h1;
    tick();
    scl <= 1'h0;
    tick();
    byte_io({a, 1'h1}, ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(1'h1, r);
    sda_low <= 1'h1;
    tick();
    scl <= 1'h1;
    tick();
    sda_low <= 1'h0;
    tick();
  endtask : rd
  task automatic hold_low(input int n);
    scl <= 1'h0;
    repeat (n) @(posedge hclk);
    scl <= 1'h1;
  endtask : hold_low
endmodule : cprc_smb_host

// *** verification/tb_crosspoint_route_control.sv ***
// testbench of the crosspoint route control block
// assumes the bus host model beside it, 100 MHz clock, short bus timeout
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_crosspoint_route_control
  import cprc_pkg::*;
();
  logic        hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0;
  logic        smb_enable_pin = 1'h0, power_down_pin = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, smb_data_oe, outputs_active, scl, sda_low;
  logic [7:0]  rs = 8'h0, tx_boost_level, rx_comp_level;
  logic [3:0]  txp = 4'h0, rxp = 4'h0, switch_in = 4'h0, sig_present = 4'hF;
  logic [3:0]  switch_output_n;
  wire         sda_line = ~(sda_low | smb_data_oe);
  int          err_total = 0, checks_done = 0, cyc = 0;

  cprc_top #(.TMO(200)) uut (
    .hclk, .hresetn, .ce(1'h1), .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .smb_enable_pin,
    .power_down_pin, .route_sel_switch_output0_bit0(smb_enable_pin ? scl : rs[0]),
    .route_sel_switch_output0_bit1(smb_enable_pin ? sda_line : rs[1]),
    .route_sel_out1_bit0(rs[2]), .route_sel_out1_bit1(rs[3]),
    .route_sel_out2_bit0(rs[4]), .route_sel_out2_bit1(rs[5]),
    .route_sel_out3_bit0(rs[6]), .route_sel_out3_bit1(rs[7]),
    .smb_data_o(), .smb_data_oe, .tx_boost_sel0(txp[0]), .tx_boost_sel1(txp[1]),
    .tx_boost_sel2(txp[2]), .tx_boost_sel3(txp[3]), .rx_comp_sel0(rxp[0]),
    .rx_comp_sel1(rxp[1]), .rx_comp_sel2(rxp[2]), .rx_comp_sel3(rxp[3]),
    .switch_in, .sig_present, .switch_output_n, .tx_boost_level, .rx_comp_level,
    .outputs_active);
  cprc_smb_host host (.hclk, .scl, .sda_low, .sda(sda_line));

  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic ahb(input logic w, input logic [31:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NSEQ;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata[7:0];
  endtask : ahb
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    ahb(1'h1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    logic [7:0] q;
    ahb(1'h0, a, 8'h0, q);
    `CHK(q, e)
  endtask : rdc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    int n;
    power_down_pin <= 1'h0;
    repeat (4) @(posedge hclk);
    `CHK(outputs_active, 1'h0)
    `CHK(switch_output_n, 4'h0)
    n = 0;
    power_down_pin <= 1'h1;
    while (outputs_active !== 1'h1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    `CHK(n >= T_ON_CYC && n <= T_ON_CYC + 4, 1'h1)
    $display("t_power end");
  endtask : t_power
  task automatic t_route();
    for (int c = 0; c < 4; c++) begin
      rs <= {4{2'(c)}};
      switch_in <= 4'h1 << c;
      repeat (4) @(posedge hclk);
      `CHK(switch_output_n, 4'hF)
      switch_in <= ~(4'h1 << c);
      repeat (3) @(posedge hclk);
      `CHK(switch_output_n, 4'h0)
    end
    rs <= 8'h1B;
    switch_in <= 4'h3;
    repeat (4) @(posedge hclk);
    `CHK(switch_output_n, 4'hC)
    $display("t_route end");
  endtask : t_route
  task automatic t_pinlvl();
    for (int k = 0; k < 4; k++) begin
      txp <= 4'h1 << k;
      rxp <= 4'h1 << k;
      repeat (3) @(posedge hclk);
      `CHK(tx_boost_level, {6'h0, LVL_MED} << (2 * k))
      `CHK(rx_comp_level, {6'h0, LVL_LOW} << (2 * k))
    end
    txp <= 4'h0;
    rxp <= 4'h0;
    repeat (3) @(posedge hclk);
    `CHK({tx_boost_level, rx_comp_level}, 16'h0)
    $display("t_pinlvl end");
  endtask : t_pinlvl
  task automatic t_bus();
    smb_enable_pin <= 1'h1;
    power_down_pin <= 1'h0;
    repeat (3) @(posedge hclk);
    rdc(OFF_STAT, 8'h01);
    wr(OFF_CTRL, 8'h80);
    @(posedge hclk);
    rdc(OFF_STAT, 8'h03);
    wr(OFF_CTRL, 8'h00);
    power_down_pin <= 1'h1;
    rdc(OFF_STAT, 8'h03);
    wr(OFF_TXLVL, 8'hE4);
    wr(OFF_RXLVL, 8'h1B);
    repeat (3) @(posedge hclk);
    `CHK(tx_boost_level, 8'hE4)
    `CHK(rx_comp_level, 8'h1B)
    txp <= 4'h8;
    rxp <= 4'h1;
    repeat (3) @(posedge hclk);
    `CHK(tx_boost_level, 8'hA4)
    `CHK(rx_comp_level, 8'h19)
    txp <= 4'h0;
    rxp <= 4'h0;
    wr(OFF_ROUTE, 8'h1B);
    rdc(OFF_ROUTE, 8'h1B);
    wr(32'h0000_0018, 8'hFF);
    rdc(32'h0000_0018, 8'h00);
    smb_enable_pin <= 1'h0;
    repeat (3) @(posedge hclk);
    rdc(OFF_ROUTE, 8'hE4);
    rdc(OFF_TXLVL, 8'h00);
    $display("t_bus end");
  endtask : t_bus
  task automatic t_smb();
    logic [2:0] ack;
    logic [7:0] q;
    smb_enable_pin <= 1'h1;
    power_down_pin <= 1'h0;
    rs <= 8'hE8;
    repeat (3) @(posedge hclk);
    host.wr({SMB_ADDR_HI, 4'hA}, 8'h01, 8'h39, ack);
    `CHK(ack, 3'h7)
    rdc(OFF_ROUTE, 8'h39);
    wr(OFF_TXLVL, 8'hC6);
    host.rd({SMB_ADDR_HI, 4'hA}, q, ack[0]);
    `CHK({ack[0], q}, 9'h1C6)
    rs <= 8'h28;
    host.wr({SMB_ADDR_HI, 4'h5}, 8'h01, 8'h00, ack);
    `CHK(ack, 3'h0)
    rdc(OFF_ROUTE, 8'h39);
    host.hold_low(260);
    rdc(OFF_STAT, 8'h09);
    $display("t_smb end");
  endtask : t_smb
  task automatic t_los();
    sig_present <= 4'hA;
    repeat (3) @(posedge hclk);
    sig_present <= 4'hF;
    repeat (2) @(posedge hclk);
    rdc(OFF_LOS, 8'hF5);
    wr(OFF_LOS, 8'h04);
    rdc(OFF_LOS, 8'hF1);
    $display("t_los end");
  endtask : t_los
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rdc(OFF_ROUTE, 8'hE4);
    rdc(OFF_CTRL, 8'h00);
    t_power();
    t_route();
    t_pinlvl();
    t_bus();
    t_smb();
    t_los();
    print_verdict();
  end
endmodule : tb_crosspoint_route_control
